// file: src/usm_map.svh
`ifndef USM_MAP_SVH
`define USM_MAP_SVH
`define USM_A_PWR 8'h87
`define USM_A_CTRL 8'h98
`define USM_A_BUF 8'h99
`define USM_A_FRAC 8'h9D
`define USM_A_BINT 8'h9E
`define USM_A_CFG 8'hAF
`define USM_A_T2C 8'hC8
`define USM_B_RXDONE 0
`define USM_B_TXDONE 1
`define USM_B_RXSTOP 2
`define USM_B_REN 4
`define USM_B_FCHK 5
`define USM_B_DBL 7
`define USM_B_BTEN 7
`define USM_B_EXTOPT 6
`define USM_B_OVR 7
`define USM_B_FERR 6
`define USM_B_T2RX 5
`define USM_B_T2TX 4
`define USM_RST_CTRL 8'h00
`define USM_RST_FRAC 8'h00
`define USM_RST_BINT 8'h00
`define USM_M0_LAST 4'hB
`define USM_M0_HALF 4'h6
`define USM_OS_LAST 4'hF
`define USM_OS_MID 4'h7
`define USM_BIT_LAST 4'h7
`define USM_BIT_STOP 4'h8
`define USM_BIT_END 4'h9
`endif

// file: src/usm_pkg.sv
package usm_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_M0 = 2'b01,
        TX_M1 = 2'b10
    } usm_tx_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_M0 = 2'b01,
        RX_START = 2'b10,
        RX_DATA = 2'b11
    } usm_rx_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usm_bus_t;
    typedef struct packed {
        usm_tx_t tx_st;
        usm_rx_t rx_st;
        logic [7:0] ctrl;
        logic [7:0] rbuf;
        logic [7:0] frac;
        logic [7:0] bint;
        logic dbl;
        logic extopt;
        logic [1:0] t2c;
        logic [8:0] tsh;
        logic [3:0] tbit;
        logic [3:0] tsub;
        logic [7:0] rsh;
        logic [3:0] rbit;
        logic [3:0] rsub;
        logic rxd_q;
        logic t1h;
        logic [9:0] pre;
        logic [5:0] facc;
        logic swallow;
        logic [7:0] rdata;
    } usm_state_t;
endpackage : usm_pkg

// file: src/usm_uart.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "usm_map.svh"
// Overview of operation
// R1: Baud timer enable overrides all other sources.
// R2: Enable clear gives classic timer rate sources.
// R3: Fraction register bit 6 ignored, reads zero.
// R4: Six-bit fractional divisor, resets to zero.
// R5: Fraction values give tabulated baud rates.
// R6: Mode select 00 selects shift mode.
// R7: Shift mode: eight bits, clock twelfth.
// R8: Buffer write starts shift-out, LSB first.
// R9: Shift receive needs enable and clear flag.
// R10: Mode 1 frame: start, eight, stop.
// R11: Mode 1 rates from timer overflows.
// R12: Transmit-done set when stop bit appears.
// R13: Receive starts on falling receive pin.
// R14: Accept only with flag clear, unless extended.
// R15: Frame check requires stop bit one.
// R16: Failed frame discarded, flag kept.
// R17: Accepted frame: buffer, stop bit, flag.
// R18: Overrun set on arrival with flag set.
// R19: Framing error updated every frame.
// R20: Prescale and extension divide by powers.
// R21: Start bit rechecked mid-bit, false start.
// R22: Fraction swallows periods to stretch average.
module usm_uart (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire usm_pkg::usm_bus_t BUS,
    output logic [7:0] RD_DATA,
    input wire logic T1_OVF,
    input wire logic T2_OVF,
    input wire logic RXD_IN,
    output logic RXD_OUT,
    output logic RXD_OE_N,
    output logic TXD
);
    usm_pkg::usm_state_t s_r;
    usm_pkg::usm_state_t s_nxt;
    logic mode0;
    logic mode1;
    logic p;
    logic bt;
    logic t1src;
    logic tx_tick;
    logic rx_tick;
    logic rx_final;
    logic accept;
    logic buf_wr;
    logic [9:0] mask;
    logic [6:0] fsum;

    function automatic logic [9:0] usm_mask(input logic [2:0] dv, input logic [1:0] ex);
        logic [3:0] k;
        k = {1'b0, dv} + {2'b00, ex};
        usm_mask = 10'((11'h001 << k) - 11'h001);
    endfunction : usm_mask

    always_comb begin
        mode0 = s_r.ctrl[7:6] == 2'b00; // R6
        mode1 = s_r.ctrl[7:6] == 2'b01; // R10
        mask = usm_mask(s_r.bint[2:0], s_r.bint[4:3]); // R20
        p = (s_r.pre & mask) == mask;
        bt = p && !s_r.swallow; // R22
        // Without double speed only every second Timer 1 overflow counts.
        t1src = s_r.dbl ? T1_OVF : (T1_OVF && s_r.t1h);
        if (s_r.frac[`USM_B_BTEN]) begin
            tx_tick = bt; // R1
            rx_tick = bt; // R1
        end else begin
            tx_tick = s_r.t2c[`USM_B_T2TX - 4] ? T2_OVF : t1src; // R2 R11
            rx_tick = s_r.t2c[`USM_B_T2RX - 4] ? T2_OVF : t1src; // R2 R11
        end
        rx_final = s_r.rx_st == usm_pkg::RX_DATA && rx_tick && s_r.rsub == `USM_OS_LAST
            && s_r.rbit == `USM_BIT_STOP;
        accept = (s_r.extopt || !s_r.ctrl[`USM_B_RXDONE]) // R14
            && (!s_r.ctrl[`USM_B_FCHK] || RXD_IN); // R15
        buf_wr = BUS.wr && BUS.addr == `USM_A_BUF;
        fsum = {1'b0, s_r.facc} + {1'b0, s_r.frac[5:0]};
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.pre = s_r.pre + 10'h001;
        s_nxt.rxd_q = RXD_IN;
        s_nxt.rdata = 8'h00;
        if (T1_OVF) begin
            s_nxt.t1h = !s_r.t1h;
        end
        if (p) begin
            if (s_r.swallow) begin
                s_nxt.swallow = 1'b0;
            end else begin
                s_nxt.facc = fsum[5:0]; // R5 R22
                s_nxt.swallow = fsum[6]; // R22
            end
        end
        if (BUS.rd) begin
            case (BUS.addr)
                `USM_A_PWR: s_nxt.rdata = {s_r.dbl, 7'h00};
                `USM_A_CTRL: s_nxt.rdata = s_r.ctrl;
                `USM_A_BUF: s_nxt.rdata = s_r.rbuf;
                `USM_A_FRAC: s_nxt.rdata = s_r.frac;
                `USM_A_BINT: s_nxt.rdata = s_r.bint;
                `USM_A_CFG: s_nxt.rdata = {1'b0, s_r.extopt, 6'h00};
                `USM_A_T2C: s_nxt.rdata = {2'b00, s_r.t2c, 4'h0};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        if (BUS.wr) begin
            case (BUS.addr)
                `USM_A_PWR: s_nxt.dbl = BUS.wdata[`USM_B_DBL];
                `USM_A_CTRL: s_nxt.ctrl = BUS.wdata;
                `USM_A_FRAC: s_nxt.frac = {BUS.wdata[7], 1'b0, BUS.wdata[5:0]}; // R3 R4
                `USM_A_BINT: begin
                    s_nxt.bint[4:0] = BUS.wdata[4:0];
                    if (!BUS.wdata[`USM_B_OVR]) begin
                        s_nxt.bint[`USM_B_OVR] = 1'b0; // R18
                    end
                end
                `USM_A_CFG: s_nxt.extopt = BUS.wdata[`USM_B_EXTOPT];
                `USM_A_T2C: s_nxt.t2c = BUS.wdata[5:4];
                default: s_nxt.rdata = s_nxt.rdata;
            endcase
        end
        // Hardware flag sets come after the software writes so that they win.
        unique case (s_r.tx_st)
            usm_pkg::TX_IDLE: begin
                if (buf_wr && !(mode0 && s_r.rx_st != usm_pkg::RX_IDLE)) begin
                    s_nxt.tsh = {1'b1, BUS.wdata}; // R8 R12
                    s_nxt.tbit = 4'h0;
                    s_nxt.tsub = 4'h0;
                    if (mode0) begin
                        s_nxt.tx_st = usm_pkg::TX_M0; // R8
                    end else if (mode1) begin
                        s_nxt.tx_st = usm_pkg::TX_M1; // R10
                    end
                end
            end
            usm_pkg::TX_M0: begin
                if (s_r.tsub == `USM_M0_LAST) begin
                    s_nxt.tsub = 4'h0; // R7
                    s_nxt.tsh = {1'b1, s_r.tsh[8:1]}; // R8
                    s_nxt.tbit = s_r.tbit + 4'h1;
                    if (s_r.tbit == `USM_BIT_LAST) begin
                        s_nxt.tx_st = usm_pkg::TX_IDLE; // R7
                        s_nxt.ctrl[`USM_B_TXDONE] = 1'b1;
                    end
                end else begin
                    s_nxt.tsub = s_r.tsub + 4'h1;
                end
            end
            usm_pkg::TX_M1: begin
                if (tx_tick) begin
                    if (s_r.tsub == `USM_OS_LAST) begin
                        s_nxt.tsub = 4'h0;
                        s_nxt.tbit = s_r.tbit + 4'h1;
                        if (s_r.tbit != 4'h0) begin
                            s_nxt.tsh = {1'b1, s_r.tsh[8:1]}; // R10
                        end
                        if (s_r.tbit == `USM_BIT_STOP) begin
                            s_nxt.ctrl[`USM_B_TXDONE] = 1'b1; // R12
                        end
                        if (s_r.tbit == `USM_BIT_END) begin
                            s_nxt.tx_st = usm_pkg::TX_IDLE; // R10
                        end
                    end else begin
                        s_nxt.tsub = s_r.tsub + 4'h1;
                    end
                end
            end
            default: s_nxt.tx_st = usm_pkg::TX_IDLE;
        endcase
        unique case (s_r.rx_st)
            usm_pkg::RX_IDLE: begin
                s_nxt.rsub = 4'h0;
                s_nxt.rbit = 4'h0;
                if (mode0 && s_r.ctrl[`USM_B_REN] && !s_r.ctrl[`USM_B_RXDONE]
                    && s_r.tx_st == usm_pkg::TX_IDLE && !buf_wr) begin
                    s_nxt.rx_st = usm_pkg::RX_M0; // R9
                end else if (mode1 && s_r.ctrl[`USM_B_REN] && s_r.rxd_q && !RXD_IN) begin
                    s_nxt.rx_st = usm_pkg::RX_START; // R13
                end
            end
            usm_pkg::RX_M0: begin
                if (s_r.rsub == `USM_M0_HALF) begin
                    s_nxt.rsh = {RXD_IN, s_r.rsh[7:1]}; // R7
                end
                if (s_r.rsub == `USM_M0_LAST) begin
                    s_nxt.rsub = 4'h0;
                    s_nxt.rbit = s_r.rbit + 4'h1;
                    if (s_r.rbit == `USM_BIT_LAST) begin
                        s_nxt.rx_st = usm_pkg::RX_IDLE;
                        s_nxt.rbuf = s_r.rsh;
                        s_nxt.ctrl[`USM_B_RXDONE] = 1'b1; // R9
                    end
                end else begin
                    s_nxt.rsub = s_r.rsub + 4'h1;
                end
            end
            usm_pkg::RX_START: begin
                if (rx_tick) begin
                    if (s_r.rsub == `USM_OS_MID) begin
                        s_nxt.rsub = 4'h0;
                        s_nxt.rx_st = RXD_IN ? usm_pkg::RX_IDLE : usm_pkg::RX_DATA; // R21 R13
                    end else begin
                        s_nxt.rsub = s_r.rsub + 4'h1;
                    end
                end
            end
            usm_pkg::RX_DATA: begin
                if (rx_tick) begin
                    if (s_r.rsub == `USM_OS_LAST) begin
                        s_nxt.rsub = 4'h0;
                        if (s_r.rbit == `USM_BIT_STOP) begin
                            s_nxt.rx_st = usm_pkg::RX_IDLE;
                        end else begin
                            s_nxt.rsh = {RXD_IN, s_r.rsh[7:1]}; // R13
                            s_nxt.rbit = s_r.rbit + 4'h1;
                        end
                    end else begin
                        s_nxt.rsub = s_r.rsub + 4'h1;
                    end
                end
            end
        endcase
        if (rx_final) begin
            s_nxt.bint[`USM_B_FERR] = !RXD_IN; // R19
            if (s_r.ctrl[`USM_B_RXDONE]) begin
                s_nxt.bint[`USM_B_OVR] = 1'b1; // R18
            end
            if (accept) begin
                s_nxt.rbuf = s_r.rsh; // R17 R16
                s_nxt.ctrl[`USM_B_RXSTOP] = RXD_IN; // R17
                s_nxt.ctrl[`USM_B_RXDONE] = 1'b1; // R17
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            s_r <= '0;
            s_r.ctrl <= `USM_RST_CTRL;
            s_r.tsh <= 9'h1FF;
            s_r.frac <= `USM_RST_FRAC; // R4
            s_r.bint <= `USM_RST_BINT;
            s_r.rxd_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        RD_DATA = s_r.rdata;
        RXD_OUT = s_r.tsh[0]; // R8
        RXD_OE_N = s_r.tx_st != usm_pkg::TX_M0;
        if (s_r.tx_st == usm_pkg::TX_M0) begin
            TXD = s_r.tsub >= `USM_M0_HALF; // R7
        end else if (s_r.rx_st == usm_pkg::RX_M0) begin
            TXD = s_r.rsub >= `USM_M0_HALF; // R9
        end else if (s_r.tx_st == usm_pkg::TX_M1) begin
            TXD = (s_r.tbit == 4'h0) ? 1'b0 : s_r.tsh[0]; // R10
        end else begin
            TXD = 1'b1;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    sequence s_final;
        rx_final;
    endsequence
    sequence s_take;
        s_final ##0 accept;
    endsequence

    a_frame_take: assert property (s_take |=> s_r.ctrl[0] && s_r.rbuf == $past(s_r.rsh)) // R17
        else $error("accepted frame not stored");
    a_frame_drop: assert property (s_final ##0 !accept |=> s_r.rbuf == $past(s_r.rbuf)) // R16
        else $error("rejected frame changed the buffer");
    a_overrun_set: assert property (s_final ##0 s_r.ctrl[0] |=> s_r.bint[7]) // R18
        else $error("overrun not flagged");
    a_frame_error: assert property (s_final |=> s_r.bint[6] == !$past(RXD_IN)) // R19
        else $error("framing error flag wrong");
    a_frac_bit6: assert property (BUS.rd && BUS.addr == 8'h9D |=> !RD_DATA[6]) // R3
        else $error("unimplemented bit read as one");
    a_stop_done: assert property ($rose(s_r.ctrl[1]) && s_r.tx_st == usm_pkg::TX_M1 |-> TXD) // R12
        else $error("transmit done without stop bit on pin");
    a_shift_clock: assert property (s_r.tx_st == usm_pkg::TX_M0 && s_r.tsub < 4'h6 |-> !TXD) // R7
        else $error("shift clock high in first half");
    a_shift_start: assert property (buf_wr && mode0 && s_r.tx_st == usm_pkg::TX_IDLE // R8
        && s_r.rx_st == usm_pkg::RX_IDLE |=> !RXD_OE_N && RXD_OUT == $past(BUS.wdata[0]))
        else $error("shift transmit did not start");
    a_false_start: assert property (s_r.rx_st == usm_pkg::RX_START && rx_tick // R21
        && s_r.rsub == 4'h7 && RXD_IN |=> s_r.rx_st == usm_pkg::RX_IDLE)
        else $error("false start not rejected");
    a_shift_rx_gate: assert property (s_r.rx_st == usm_pkg::RX_IDLE // R9
        ##1 s_r.rx_st == usm_pkg::RX_M0 |-> $past(s_r.ctrl[4] && !s_r.ctrl[0]))
        else $error("shift receive started without enable");
endmodule : usm_uart

// file: bench/usm_remote.sv
`timescale 1ns/1ps
// Far-side peer: an 8N1 serial device in mode 1, a shift register in mode 0.
module usm_remote (
    input wire logic REF_CLK,
    input wire logic TXD,
    input wire logic RXD_OUT,
    input wire logic RXD_OE_N,
    output logic SER_DRV
);
    int bit_cyc = 16;
    logic shift_mode = 1'b0;
    logic [7:0] m0_pat = 8'h00;
    logic [7:0] m0_got = 8'h00;
    logic [7:0] got = 8'h00;
    logic got_stop = 1'b0;
    logic txd_q = 1'b1;
    initial SER_DRV = 1'b1;
    always @(posedge REF_CLK) begin
        txd_q <= TXD;
        if (shift_mode && !txd_q && TXD && !RXD_OE_N) begin
            m0_got <= {RXD_OUT, m0_got[7:1]};
        end
        if (shift_mode && txd_q && !TXD && RXD_OE_N) begin
            SER_DRV <= m0_pat[0];
            m0_pat <= {~m0_pat[0], m0_pat[7:1]};
        end
    end
    // Each bit is sampled in its middle, counted from the falling start edge.
    always @(posedge REF_CLK) begin
        if (!shift_mode && txd_q && !TXD) begin
            repeat (bit_cyc / 2) @(posedge REF_CLK);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge REF_CLK);
                got[i] = TXD;
            end
            repeat (bit_cyc) @(posedge REF_CLK);
            got_stop = TXD;
        end
    end
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge REF_CLK);
            SER_DRV <= f[i];
            repeat (bit_cyc - 1) @(posedge REF_CLK);
        end
        @(posedge REF_CLK);
        SER_DRV <= 1'b1;
    endtask : send
    // A low pulse far shorter than half a bit, then a quiet line.
    task automatic glitch();
        @(posedge REF_CLK);
        SER_DRV <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        SER_DRV <= 1'b1;
        repeat (bit_cyc * 2) @(posedge REF_CLK);
    endtask : glitch
endmodule : usm_remote

// file: bench/usm_uart_bench.sv
`timescale 1ns/1ps
`include "usm_map.svh"
module usm_uart_bench;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    usm_pkg::usm_bus_t BUS = '0;
    logic T1_OVF = 1'b0;
    logic T2_OVF = 1'b0;
    logic [7:0] RD_DATA;
    logic RXD_IN;
    logic RXD_OUT;
    logic RXD_OE_N;
    logic TXD;
    logic ser_drv;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int t;
    logic [7:0] rv;
    logic [31:0] cfgs [6] = '{32'h80008030, 32'h80010000, 32'h00008000,
        32'h00000000, 32'h00000030, 32'h87000000};
    int bcs [6] = '{16, 32, 32, 64, 64, 17};
    // The receive pin carries the device's drive while its enable is low.
    assign RXD_IN = RXD_OE_N ? ser_drv : RXD_OUT;
    always #2 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        T1_OVF <= (cyc % 2 == 0);
        T2_OVF <= (cyc % 4 == 0);
    end
    usm_uart uut (.REF_CLK(REF_CLK), .RESET(RESET), .BUS(BUS), .RD_DATA(RD_DATA),
        .T1_OVF(T1_OVF), .T2_OVF(T2_OVF), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT),
        .RXD_OE_N(RXD_OE_N), .TXD(TXD));
    usm_remote peer (.REF_CLK(REF_CLK), .TXD(TXD), .RXD_OUT(RXD_OUT),
        .RXD_OE_N(RXD_OE_N), .SER_DRV(ser_drv));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge REF_CLK);
        BUS.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge REF_CLK);
        BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge REF_CLK);
        BUS.rd <= 1'b0;
        #1 d = RD_DATA;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask : rc
    task automatic wait_flag(input int b, input int lim, output int tw);
        int t0;
        t0 = cyc;
        rv = 8'h00;
        while (rv[b] !== 1'b1 && cyc - t0 < lim) rd(`USM_A_CTRL, rv);
        tw = cyc - t0;
    endtask : wait_flag
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (100000) @(posedge REF_CLK);
        mismatches++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        rc(`USM_A_CTRL, 8'h00, "control reset");
        rc(`USM_A_FRAC, 8'h00, "fraction reset");
        rc(`USM_A_BINT, 8'h00, "integer reset");
        rc(8'h80, 8'h00, "unmapped");
        wr(`USM_A_FRAC, 8'hFF);
        rc(`USM_A_FRAC, 8'hBF, "fraction bits");
        $display("test registers done");
        for (int k = 0; k < 6; k++) begin
            wr(`USM_A_FRAC, cfgs[k][31:24]);
            wr(`USM_A_BINT, cfgs[k][23:16]);
            wr(`USM_A_PWR, cfgs[k][15:8]);
            wr(`USM_A_T2C, cfgs[k][7:0]);
            peer.bit_cyc = bcs[k];
            wr(`USM_A_CTRL, 8'h50);
            wr(`USM_A_BUF, 8'(8'hA5 ^ k));
            wait_flag(1, 12 * bcs[k], t);
            chk("tx time", 1'b1, t >= 8 * bcs[k] && t <= 10 * bcs[k]);
            repeat (bcs[k] * 2) @(posedge REF_CLK);
            chk("tx byte", 8'(8'hA5 ^ k), peer.got);
            chk("tx stop", 1'b1, peer.got_stop);
            peer.send(8'(8'h3C + k), 1'b1);
            wait_flag(0, 4 * bcs[k], t);
            rc(`USM_A_CTRL, 8'h57, "rx flags");
            rc(`USM_A_BUF, 8'(8'h3C + k), "rx byte");
        end
        $display("test rates done");
        wr(`USM_A_FRAC, 8'h80);
        wr(`USM_A_BINT, 8'h00);
        peer.bit_cyc = 16;
        peer.send(8'h99, 1'b1);
        repeat (32) @(posedge REF_CLK);
        rc(`USM_A_BUF, 8'h41, "kept byte");
        rc(`USM_A_CTRL, 8'h57, "kept flags");
        rc(`USM_A_BINT, 8'h80, "overrun set");
        wr(`USM_A_BINT, 8'h00);
        rc(`USM_A_BINT, 8'h00, "overrun clear");
        wr(`USM_A_CTRL, 8'h70);
        peer.send(8'h66, 1'b0);
        repeat (32) @(posedge REF_CLK);
        rc(`USM_A_CTRL, 8'h70, "bad stop flags");
        rc(`USM_A_BINT, 8'h40, "framing set");
        peer.glitch();
        peer.send(8'h81, 1'b1);
        repeat (32) @(posedge REF_CLK);
        rc(`USM_A_CTRL, 8'h75, "after false start");
        rc(`USM_A_BUF, 8'h81, "after false start");
        rc(`USM_A_BINT, 8'h00, "framing clear");
        $display("test acceptance done");
        peer.shift_mode = 1'b1;
        peer.m0_pat = 8'h5A;
        wr(`USM_A_CTRL, 8'h00);
        wr(`USM_A_BUF, 8'hC3);
        wait_flag(1, 150, t);
        chk("shift time", 1'b1, t >= 94 && t <= 106);
        chk("shift out", 8'hC3, peer.m0_got);
        wr(`USM_A_CTRL, 8'h10);
        wait_flag(0, 150, t);
        rc(`USM_A_CTRL, 8'h11, "shift rx flags");
        rc(`USM_A_BUF, 8'h5A, "shift in");
        $display("test shift done");
        final_report();
    end
endmodule : usm_uart_bench
